// >>> src/uic_irq_ctrl.sv
// Interrupt controller: pending flops, masking, priority, forced call.
// Assumes the core signals instruction boundaries and the enable, disable and return instructions,
// and that event inputs are one-cycle pulses on this clock.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module uic_irq_ctrl #(
	parameter int DAC_W = 8
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [7:0]        paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              usb_dp,
	input  wire logic              usb_dm,
	input  wire logic              startup_active,
	input  wire logic              tick_128us,
	input  wire logic              tick_1ms,
	input  wire logic [4:0]        ep_handshake,
	input  wire uic_pkg::uic_hub_t hub_ev,
	input  wire logic [DAC_W-1:0]  dac_pins,
	input  wire logic              gpio_irq,
	input  wire logic              serial_irq,
	input  wire uic_pkg::uic_cpu_t cpu,
	output uic_pkg::uic_call_t     call_out,
	output logic                   gie,
	output logic                   bus_reset_clear,
	output logic                   startup_abort
);
	import uic_pkg::*;

	typedef enum logic [1:0] {S_IDLE, S_CALL, S_JUMP} uic_state_t;

	logic [6:0]       glob_en_q;
	logic [4:0]       ep_en_q;
	logic [DAC_W-1:0] dac_en_q;
	logic [DAC_W-1:0] dac_pol_q;
	logic             busrst_flag_q;
	logic [NSRC-1:0]  pend_q;
	logic [NSRC-1:0]  set_ev;
	logic [NSRC-1:0]  clr_ev;
	logic [NSRC-1:0]  en_vec;
	logic [NSRC-1:0]  req;
	logic [3:0]       win;
	logic             take;
	logic             gie_q;
	uic_state_t       st_q;
	logic [3:0]       seq_q;
	uic_call_t        call_q;
	logic [31:0]      prdata_q;
	logic             pready_q;
	logic             pslverr_q;
	logic             wr;
	logic             setup;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// No wait state; pready and prdata come from flops loaded in the setup phase
	assign setup = psel && !penable && !pready_q;
	assign wr    = psel && penable && pready_q && pwrite;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= 1'b0;
			if (setup) begin
				prdata_q <= 32'h0;
				case (paddr)
				OFS_GLOBAL_EN: prdata_q[6:0] <= glob_en_q;
				OFS_EP_EN:     prdata_q[4:0] <= ep_en_q;
				OFS_STATUS: begin
					prdata_q[BIT_GIE_SENSE] <= gie_q;
					prdata_q[BIT_BUS_RST]   <= busrst_flag_q;
					prdata_q[BIT_IRQ_PEND]  <= |pend_q;
				end
				OFS_PENDING:   prdata_q[NSRC-1:0] <= pend_q;
				OFS_DAC_EN:    prdata_q[DAC_W-1:0] <= dac_en_q;
				OFS_DAC_POL:   prdata_q[DAC_W-1:0] <= dac_pol_q;
				default:       pslverr_q <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			glob_en_q <= RST_GLOBAL_EN;
			ep_en_q   <= RST_EP_EN;
			dac_en_q  <= '0;
			dac_pol_q <= '0;
		end else if (wr) begin
			if (paddr == OFS_GLOBAL_EN)
				glob_en_q <= pwdata[6:0];
			if (paddr == OFS_EP_EN)
				ep_en_q <= pwdata[4:0];
			if (paddr == OFS_DAC_EN)
				dac_en_q <= pwdata[DAC_W-1:0];
			if (paddr == OFS_DAC_POL)
				dac_pol_q <= pwdata[DAC_W-1:0];
		end
	end

	// ----------------------------------------
	// Upstream SE0 detection
	// ----------------------------------------
	logic [1:0] dp_s_q;
	logic [1:0] dm_s_q;
	logic       se0;
	logic [9:0] se0_cnt_q;
	logic       se0_seen_q;
	logic       busrst_det;
	logic       busrst_clr_q;
	logic       abort_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dp_s_q <= 2'h3;
			dm_s_q <= 2'h3;
		end else begin
			dp_s_q <= {dp_s_q[0], usb_dp};
			dm_s_q <= {dm_s_q[0], usb_dm};
		end
	end

	assign se0 = !dp_s_q[1] && !dm_s_q[1];
	// Recognised at the 12 us bound, well inside the 16 us limit
	assign busrst_det = se0 && (se0_cnt_q == 10'(SE0_MIN_CYC - 1));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			se0_cnt_q  <= 10'h0;
			se0_seen_q <= 1'b0;
		end else begin
			if (!se0)
				se0_cnt_q <= 10'h0;
			else if (se0_cnt_q != 10'(SE0_MAX_CYC))
				se0_cnt_q <= se0_cnt_q + 10'h1;
			if (busrst_det)
				se0_seen_q <= 1'b1;
			else if (!se0)
				se0_seen_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busrst_flag_q <= 1'b0;
			busrst_clr_q  <= 1'b0;
			abort_q       <= 1'b0;
		end else begin
			busrst_clr_q <= busrst_det;
			abort_q      <= busrst_det && startup_active;
			// Hardware set wins over a software write of zero
			if (busrst_det)
				busrst_flag_q <= 1'b1;
			else if (wr && paddr == OFS_STATUS && !pwdata[BIT_BUS_RST])
				busrst_flag_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// DAC edge interrupt with pin lock
	// ----------------------------------------
	logic [DAC_W-1:0] dac_s1_q;
	logic [DAC_W-1:0] dac_s2_q;
	logic [DAC_W-1:0] dac_act_prev_q;
	logic [DAC_W-1:0] dac_act;
	logic [DAC_W-1:0] dac_rise;
	logic [DAC_W-1:0] dac_lock_q;
	logic [DAC_W-1:0] dac_pick;
	logic             dac_ev;

	assign dac_act  = ~(dac_s2_q ^ dac_pol_q);
	assign dac_rise = dac_act & ~dac_act_prev_q & dac_en_q;
	assign dac_pick = dac_rise & (~dac_rise + DAC_W'(1));
	assign dac_ev   = (dac_lock_q == '0) && (dac_rise != '0);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dac_s1_q       <= '0;
			dac_s2_q       <= '0;
			dac_act_prev_q <= '1;
			dac_lock_q     <= '0;
		end else begin
			dac_s1_q       <= dac_pins;
			dac_s2_q       <= dac_s1_q;
			dac_act_prev_q <= dac_act;
			if (dac_ev)
				dac_lock_q <= dac_pick;
			else if ((dac_lock_q & dac_act & dac_en_q) == '0)
				dac_lock_q <= '0;
		end
	end

	// ----------------------------------------
	// Pending flops and arbitration
	// ----------------------------------------
	always_comb begin
		set_ev = '0;
		set_ev[SRC_BUS_RST] = se0_seen_q && !se0;
		set_ev[SRC_T128] = tick_128us;
		set_ev[SRC_T1MS] = tick_1ms;
		set_ev[SRC_EP0 +: 5] = ep_handshake;
		set_ev[SRC_HUB] = |(hub_ev.conn_change & ~hub_ev.port_forced)
			|| |((hub_ev.babble | hub_ev.resume) & hub_ev.port_enable);
		set_ev[SRC_DAC] = dac_ev;
		set_ev[SRC_GPIO] = gpio_irq;
		set_ev[SRC_SER] = serial_irq;
	end

	always_comb begin
		en_vec = {glob_en_q[6:3], ep_en_q, glob_en_q[2:0]};
		req = pend_q & en_vec;
		win = 4'h0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (req[i])
				win = 4'(i);
		end
	end

	assign take = (st_q == S_IDLE) && cpu.instr_done && gie_q
		&& (req != '0);

	always_comb begin
		clr_ev = '0;
		if (take)
			clr_ev[win] = 1'b1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pend_q <= '0;
		else
			pend_q <= (pend_q & ~clr_ev) | set_ev;
	end

	// ----------------------------------------
	// Global enable and forced call
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			gie_q <= 1'b0;
		else if (take)
			gie_q <= 1'b0;
		else if (cpu.irq_disable_instruction)
			gie_q <= 1'b0;
		else if (cpu.irq_enable_instruction
			|| cpu.return_from_irq_instruction)
			gie_q <= 1'b1;
	end

	// No new entry starts until the handler's first instruction
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q   <= S_IDLE;
			seq_q  <= 4'h0;
			call_q <= '{1'b0, 1'b0, 1'b0, RESET_VECTOR};
		end else begin
			call_q.stack_push    <= 1'b0;
			call_q.handler_start <= 1'b0;
			case (st_q)
			S_IDLE: begin
				if (take) begin
					st_q              <= S_CALL;
					seq_q             <= CALL_CYC - 4'h1;
					call_q.call       <= 1'b1;
					call_q.stack_push <= 1'b1;
					call_q.vector     <= {9'h0, win + 4'h1, 1'b0};
				end
			end
			S_CALL: begin
				seq_q <= seq_q - 4'h1;
				if (seq_q == 4'h0) begin
					st_q        <= S_JUMP;
					seq_q       <= JUMP_CYC - 4'h1;
					call_q.call <= 1'b0;
				end
			end
			S_JUMP: begin
				seq_q <= seq_q - 4'h1;
				if (seq_q == 4'h0) begin
					st_q                 <= S_IDLE;
					call_q.handler_start <= 1'b1;
				end
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end

	assign prdata          = prdata_q;
	assign pready          = pready_q;
	assign pslverr         = pslverr_q;
	assign call_out        = call_q;
	assign gie             = gie_q;
	assign bus_reset_clear = busrst_clr_q;
	assign startup_abort   = abort_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_take_clears_gie;
		take |=> !gie_q && call_q.call && call_q.stack_push;
	endproperty
	a_take_clears_gie: assert property (p_take_clears_gie)
		else $error("Entry did not clear enable or start call");

	property p_entry_len;
		$rose(call_q.call) |-> call_q.call[*5] ##1 call_q.call[*5]
			##1 !call_q.call ##5 call_q.handler_start;
	endproperty
	a_entry_len: assert property (p_entry_len)
		else $error("Interrupt entry length wrong");

	property p_boundary;
		$rose(call_q.call) |-> $past(cpu.instr_done) && $past(gie_q);
	endproperty
	a_boundary: assert property (p_boundary)
		else $error("Call started off an instruction boundary");

	property p_vector;
		take |=> call_q.vector == {9'h0, $past(win) + 4'h1, 1'b0}
			&& (!pend_q[$past(win)] || $past(set_ev[win]));
	endproperty
	a_vector: assert property (p_vector)
		else $error("Vector or pending clear wrong");

	property p_masked;
		(st_q == S_IDLE) && (req == '0) |=> !$rose(call_q.call);
	endproperty
	a_masked: assert property (p_masked)
		else $error("Call with no enabled request");

	property p_busrst_end;
		se0_seen_q && !se0 |=> pend_q[SRC_BUS_RST];
	endproperty
	a_busrst_end: assert property (p_busrst_end)
		else $error("Bus reset pending not raised at SE0 end");

	property p_se0_flag;
		busrst_det |=> busrst_flag_q && busrst_clr_q;
	endproperty
	a_se0_flag: assert property (p_se0_flag)
		else $error("Bus reset not recorded");

	property p_dac_lock;
		(dac_lock_q != '0) |-> !set_ev[SRC_DAC];
	endproperty
	a_dac_lock: assert property (p_dac_lock)
		else $error("DAC interrupt while another pin locked");

	property p_ei;
		cpu.irq_enable_instruction && !take
			&& !cpu.irq_disable_instruction |=> gie_q;
	endproperty
	a_ei: assert property (p_ei)
		else $error("Enable instruction ignored");

	c_entry: cover property ($rose(call_q.handler_start));
	c_two_req: cover property (take && $countones(req) > 1);
	c_busrst: cover property (set_ev[SRC_BUS_RST]);
	c_dac: cover property (dac_ev);
endmodule

// >>> src/uic_pkg.sv
// Constants, types and register map of the interrupt controller.
// Assumes a single 50 MHz clock shared with the core and peripherals.
// How it works
// - Endpoint enable bits 0..4; bits 7..5 reserved
// - Reset clears both enable registers
// - One pending flop per source, held until serviced
// - Pending requests only when its enable set
// - Service only at instruction boundary
// - Clear global enable, pending, then call
// - Call pushes PC and flags; return re-enables
// - Enable/disable instructions touch global enable only
// - Status bit 7 shows any pending source
// - Lowest vector number wins priority
// - Reset at 0x0000; vectors two bytes apart
// - Vectors 0x0002 through 0x0018 in order
// - Entry takes ten call plus five jump cycles
// - SE0 of 12 to 16 us is bus reset
// - Bus reset sets status bit 5
// - Bus reset clears address and hub registers
// - Bus reset pending raised when SE0 ends
// - Bus reset aborts power-on start-up delay
// - Endpoint interrupt on final handshake only
// - Hub interrupt on gated connect, babble, resume
// - DAC edge interrupt, polarity, one pin locks
// - Global enable bit layout, bit 7 reserved
package uic_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] OFS_GLOBAL_EN = 8'h00;
	localparam logic [7:0] OFS_EP_EN     = 8'h04;
	localparam logic [7:0] OFS_STATUS    = 8'h08;
	localparam logic [7:0] OFS_PENDING   = 8'h0c;
	localparam logic [7:0] OFS_DAC_EN    = 8'h10;
	localparam logic [7:0] OFS_DAC_POL   = 8'h14;
	localparam int BIT_GIE_SENSE = 2;
	localparam int BIT_BUS_RST   = 5;
	localparam int BIT_IRQ_PEND  = 7;
	localparam logic [6:0] RST_GLOBAL_EN = 7'h00;
	localparam logic [4:0] RST_EP_EN     = 5'h00;
	// ----------------------------------------
	// Sources and vectors
	// ----------------------------------------
	localparam int NSRC = 12;
	localparam int SRC_BUS_RST = 0;
	localparam int SRC_T128 = 1;
	localparam int SRC_T1MS = 2;
	localparam int SRC_EP0 = 3;
	localparam int SRC_HUB = 8;
	localparam int SRC_DAC = 9;
	localparam int SRC_GPIO = 10;
	localparam int SRC_SER = 11;
	localparam logic [13:0] RESET_VECTOR = 14'h0000;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 20;
	localparam int SE0_MIN_NS = 12000;
	localparam int SE0_MAX_NS = 16000;
	localparam int SE0_MIN_CYC = (SE0_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int SE0_MAX_CYC = SE0_MAX_NS / CLK_NS;
	localparam logic [3:0] CALL_CYC = 4'ha;
	localparam logic [3:0] JUMP_CYC = 4'h5;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic instr_done;
		logic irq_enable_instruction;
		logic irq_disable_instruction;
		logic return_from_irq_instruction;
	} uic_cpu_t;
	typedef struct packed {
		logic [3:0] conn_change;
		logic [3:0] babble;
		logic [3:0] resume;
		logic [3:0] port_enable;
		logic [3:0] port_forced;
	} uic_hub_t;
	typedef struct packed {
		logic        call;
		logic        stack_push;
		logic        handler_start;
		logic [13:0] vector;
	} uic_call_t;
endpackage

// >>> tb/uic_core_model.sv
// Behavioural processor core facing the interrupt controller.
// Assumes the controller's call_out carrier and cpu strobes.
`timescale 1ns/1ps
module uic_core_model
	import uic_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire uic_call_t  call_out,
	input  wire logic [2:0] cmd,
	output uic_cpu_t        cpu,
	output logic [3:0]      depth
);
	// ----------------------------------------
	// Instruction stream
	// ----------------------------------------
	logic [1:0] cnt_q;
	logic       busy_q;
	logic [2:0] req_q;
	logic       bnd;
	// Three-cycle instructions; no boundary while an entry runs
	assign bnd = cnt_q == 2'h2 && !busy_q && !call_out.call;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 2'h0;
			busy_q <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
			if (call_out.stack_push)
				busy_q <= 1'b1;
			else if (call_out.handler_start)
				busy_q <= 1'b0;
		end
	end
	// Requested instructions execute at the next boundary
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu <= '0;
			req_q <= 3'h0;
		end else begin
			cpu.instr_done <= bnd;
			cpu.irq_enable_instruction <= bnd & req_q[0];
			cpu.irq_disable_instruction <= bnd & req_q[1];
			cpu.return_from_irq_instruction <= bnd & req_q[2];
			req_q <= bnd ? cmd : (req_q | cmd);
		end
	end
	// Stack depth: PC, carry_flag and zero_flag pushed as one frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			depth <= 4'h0;
		else if (call_out.stack_push)
			depth <= depth + 4'h1;
		else if (cpu.return_from_irq_instruction)
			depth <= depth - 4'h1;
	end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the interrupt controller over APB.
// Assumes the core model drives the cpu strobes.
`timescale 1ns/1ps
module testbench;
	import uic_pkg::*;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr;
	logic        usb_dp, usb_dm, startup_active, tick_128us, tick_1ms;
	logic        gpio_irq, serial_irq, gie, bus_reset_clear, startup_abort;
	logic [7:0]  paddr, dac_pins;
	logic [31:0] pwdata, prdata, rdat;
	logic        rerr;
	logic [4:0]  ep_handshake;
	logic [2:0]  cmd;
	logic [3:0]  depth;
	uic_hub_t    hub_ev;
	uic_cpu_t    cpu;
	uic_call_t   call_out;
	int          n_fail, compares, cyc, n_push, n_clr, n_abort;
	uic_irq_ctrl uic_irq_ctrl_inst (.clk(clk), .rst(rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.usb_dp(usb_dp), .usb_dm(usb_dm), .startup_active(startup_active),
		.tick_128us(tick_128us), .tick_1ms(tick_1ms),
		.ep_handshake(ep_handshake), .hub_ev(hub_ev), .dac_pins(dac_pins),
		.gpio_irq(gpio_irq), .serial_irq(serial_irq), .cpu(cpu),
		.call_out(call_out), .gie(gie), .bus_reset_clear(bus_reset_clear),
		.startup_abort(startup_abort));
	uic_core_model uic_core_model_inst (.clk(clk), .rst(rst),
		.call_out(call_out), .cmd(cmd), .cpu(cpu), .depth(depth));
	// ----------------------------------------
	// Clock, monitors, timeout
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		n_push += call_out.stack_push === 1'b1;
		n_clr += bus_reset_clear === 1'b1;
		n_abort += startup_abort === 1'b1;
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic conclude();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	task automatic core(input logic [2:0] c);
		cmd <= c;
		@(posedge clk);
		cmd <= 3'h0;
		repeat (6) @(posedge clk);
	endtask
	task automatic fire(input int i);
		case (i)
			1: tick_128us <= 1'b1;
			2: tick_1ms <= 1'b1;
			3, 4, 5, 6, 7: ep_handshake[i-3] <= 1'b1;
			8: hub_ev.conn_change[0] <= 1'b1;
			9: dac_pins[0] <= 1'b1;
			10: gpio_irq <= 1'b1;
			11: serial_irq <= 1'b1;
			default: begin
				tick_1ms <= 1'b1;
				serial_irq <= 1'b1;
			end
		endcase
		@(posedge clk);
		tick_128us <= 1'b0;
		tick_1ms <= 1'b0;
		ep_handshake <= 5'h00;
		hub_ev.conn_change <= 4'h0;
		gpio_irq <= 1'b0;
		serial_irq <= 1'b0;
	endtask
	// Entry: vector, global enable dropped, 15 cycles to the handler
	task automatic take(input logic [13:0] v);
		int n;
		n = 0;
		while (call_out.call !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk(call_out.vector, v);
		chk(gie, 1'b0);
		n = 0;
		while (call_out.handler_start !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk(n, 15);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = '1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{startup_active, tick_128us, tick_1ms, gpio_irq, serial_irq} = '0;
		{usb_dp, usb_dm, ep_handshake, dac_pins, cmd} = 2'b10 << 16;
		hub_ev = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFS_GLOBAL_EN, 32'h0);
		rd(OFS_EP_EN, 32'h0);
		rd(OFS_STATUS, 32'h0);
		apb(1'b0, 8'h1c, 32'h0);
		chk(rdat, 32'h0);
		chk(rerr, 32'h1);
		apb(1'b1, OFS_EP_EN, 32'hff);
		rd(OFS_EP_EN, 32'h1f);
		startup_active <= 1'b1;
		usb_dp <= 1'b0;
		repeat (650) @(posedge clk);
		rd(OFS_STATUS, 32'h20);
		rd(OFS_PENDING, 32'h0);
		usb_dp <= 1'b1;
		startup_active <= 1'b0;
		repeat (5) @(posedge clk);
		rd(OFS_PENDING, 32'h1);
		chk(n_clr, 1);
		chk(n_abort, 1);
		apb(1'b1, OFS_STATUS, 32'h0);
		rd(OFS_STATUS, 32'h80);
		fire(1);
		core(3'h1);
		repeat (20) @(posedge clk);
		chk(n_push, 0);
		rd(OFS_PENDING, 32'h3);
		rd(OFS_STATUS, 32'h84);
		apb(1'b1, OFS_DAC_EN, 32'h1);
		apb(1'b1, OFS_DAC_POL, 32'h1);
		apb(1'b1, OFS_GLOBAL_EN, 32'hff);
		take(14'h0002);
		rd(OFS_PENDING, 32'h2);
		core(3'h4);
		take(14'h0004);
		core(3'h4);
		for (int i = 2; i < 12; i++) begin
			fire(i);
			take(14'(2 * (i + 1)));
			core(3'h4);
		end
		rd(OFS_GLOBAL_EN, 32'h7f);
		core(3'h2);
		hub_ev.port_forced <= 4'h1;
		hub_ev.babble <= 4'h2;
		fire(8);
		hub_ev.babble <= 4'h0;
		rd(OFS_PENDING, 32'h0);
		fire(13);
		rd(OFS_STATUS, 32'h80);
		core(3'h1);
		take(14'h0006);
		core(3'h4);
		take(14'h0018);
		core(3'h4);
		apb(1'b1, OFS_GLOBAL_EN, 32'h79);
		fire(1);
		repeat (20) @(posedge clk);
		chk(n_push, 14);
		chk(depth, 4'h0);
		chk(gie, 1'b1);
		conclude();
	end
endmodule
